//--- core/smc_decoder.sv
// smc_decoder: turns cyclic output image updates into motion actions.
// Behaviour
// [RULE_01] act only on a zero-to-one edge of a command bit; bits 12 and 11 are taken as levels
// [RULE_02] master lets at most one primary bit rise per update
// [RULE_03] commands live in a primary and a modifier sixteen-bit word
// [RULE_04] image: two words, position, velocity, accel, decel, current, jerk
// [RULE_05] primary bit 15 zero selects command mode
// [RULE_06] bit 14 edge loads feedback counter from position
// [RULE_07] bit 13 edge runs assembled move; modifier bit 9 picks dwell
// [RULE_08] dwell move takes dwell milliseconds from data word 9
// [RULE_09] modifier bit 4 makes blend move counter-clockwise
// [RULE_10] bits 12 and 11 program and read back assembled segments
// [RULE_11] bit 10 edge clears command errors, move complete, power fault
// [RULE_12] bit 9 edge presets motor position from position or feedback
// [RULE_13] position preset clears move complete and position invalid
// [RULE_14] bit 8 edge jogs counter-clockwise, bit 7 clockwise
// [RULE_15] modifier bit 7 turns a jog into a registration move
// [RULE_16] bit 6 edge homes counter-clockwise, bit 5 clockwise
// [RULE_17] bit 4 edge stops at once; invalidates position if moving
// [RULE_18] windings shorted at most 300 ms, then current and stopped flag
// [RULE_19] bit 2 edge holds the move down to starting speed
// [RULE_20] bit 3 edge resumes a held move; new move cancels hold
// [RULE_21] bit 1 edge starts relative move, bit 0 absolute move
// [RULE_22] configuration checks raise a configuration error
// [RULE_23] modifier bit 15 enables current, refused on configuration error
// [RULE_24] edges found against the previous update's primary word
// assumes image_i holds between updates; the engine reports status.
`include "smc_defs.svh"
`default_nettype none
module smc_decoder
  import smc_pkg::*;
#(
  parameter int SHORT_CYC = `SMC_SHORT_CYC,
  parameter int CW = 26
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // cyclic output image
  input wire logic update_i,
  input wire smc_image_t image_i,
  input wire logic [15:0] dwell_word_i,
  // configuration
  input wire logic [15:0] cfg0_i,
  input wire logic [15:0] cfg1_i,
  input wire logic param_bad_i,
  // motion engine status
  input wire logic move_active_i,
  input wire logic move_done_i,
  input wire logic cmd_error_i,
  input wire logic power_fault_i,
  input wire logic signed [31:0] feedback_pos_i,
  input wire logic [31:0] steps_per_turn_i,
  input wire logic [31:0] pulses_per_turn_i,
  // motion engine commands
  output smc_move_cmd_t move_cmd_o,
  output logic hold_o,
  output logic resume_o,
  output logic cancel_hold_o,
  output logic prog_asm_o,
  output logic read_asm_o,
  output logic mode_config_o,
  // position presets
  output logic feedback_load_o,
  output logic signed [31:0] feedback_value_o,
  output logic motor_pos_load_o,
  output logic signed [31:0] motor_pos_value_o,
  // drive stage
  output logic windings_short_o,
  output logic current_enable_o,
  // status
  output logic cmd_error_o,
  output logic power_fault_o,
  output logic move_complete_o,
  output logic position_invalid_o,
  output logic stopped_o,
  output logic cfg_error_o
);

  // -----------------------------------------------------------------------
  // edge detection
  // -----------------------------------------------------------------------
  logic [15:0] rise;
  logic cfg_err;
  // [RULE_24] compare with previous update
  smc_edge_detect #(.W(16)) smc_edge_detect_inst (
    .clk_i(clk_i), .reset_i(reset_i), .update_i(update_i),
    .word_i(image_i.primary_command_word), .rise_o(rise)
  );
  smc_cfg_check smc_cfg_check_inst (
    .cfg0_i(cfg0_i), .cfg1_i(cfg1_i), .param_bad_i(param_bad_i),
    .cfg_error_o(cfg_err)
  );

  // -----------------------------------------------------------------------
  // decode
  // -----------------------------------------------------------------------
  // [RULE_03] primary and modifier words
  wire logic [15:0] mod = image_i.modifier_command_word;
  // [RULE_05] command mode only
  wire logic cmd_mode = !image_i.primary_command_word[`SMC_P_MODE];
  // [RULE_01] act on rising edges only
  wire logic [15:0] act = cmd_mode ? rise : 16'h0000;
  wire logic go_abs = act[`SMC_P_ABS];
  wire logic go_rel = act[`SMC_P_REL];
  wire logic go_hold = act[`SMC_P_HOLD];
  wire logic go_resume = act[`SMC_P_RESUME];
  wire logic go_stop = act[`SMC_P_ISTOP];
  wire logic go_home_cw = act[`SMC_P_HOME_CW];
  wire logic go_home_ccw = act[`SMC_P_HOME_CCW];
  wire logic go_run_cw_continuous = act[`SMC_P_RUN_CW_CONTINUOUS];
  wire logic go_run_ccw_continuous = act[`SMC_P_RUN_CCW_CONTINUOUS];
  wire logic go_preset = act[`SMC_P_PRESET_POS];
  wire logic go_reset = act[`SMC_P_RESET_ERR];
  wire logic go_asm = act[`SMC_P_RUN_ASM];
  wire logic go_enc = act[`SMC_P_PRESET_ENC];
  wire logic go_jog = go_run_cw_continuous | go_run_ccw_continuous;
  wire logic go_home = go_home_cw | go_home_ccw;
  wire logic go_move = go_abs | go_rel | go_jog | go_home | go_asm;
  wire logic asm_dwell = mod[`SMC_M_ASM_TYPE];

  // [RULE_07] [RULE_14] [RULE_15] [RULE_16] [RULE_21] move kind
  wire smc_move_t kind_sel =
    go_abs ? SMC_MV_ABS :
    go_rel ? SMC_MV_REL :
    go_jog ? (mod[`SMC_M_REG_MOVE] ? SMC_MV_REG : SMC_MV_JOG) :
    go_home ? SMC_MV_HOME :
    go_asm ? (asm_dwell ? SMC_MV_DWELL : SMC_MV_BLEND) : SMC_MV_NONE;
  // [RULE_09] blend direction; clockwise when the bit is zero
  wire logic ccw_sel = go_run_ccw_continuous | go_home_ccw |
                       (go_asm && !asm_dwell && mod[`SMC_M_BLEND_REV]);

  // [RULE_12] scaled feedback position
  logic signed [63:0] scaled;
  assign scaled = (pulses_per_turn_i == 32'h0000_0000) ? 64'sh0 :
    (64'(feedback_pos_i) * $signed({32'h0, steps_per_turn_i})) /
    $signed({32'h0, pulses_per_turn_i});

  // -----------------------------------------------------------------------
  // command outputs
  // -----------------------------------------------------------------------
  // [RULE_04] [RULE_08] latch parameters with the command
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      move_cmd_o <= '0;
    end else begin
      move_cmd_o.valid <= go_move;
      if (go_move) begin
        move_cmd_o.kind <= kind_sel;
        move_cmd_o.ccw <= ccw_sel;
        move_cmd_o.position <= image_i.position;
        move_cmd_o.velocity <= image_i.velocity;
        move_cmd_o.accel <= image_i.accel;
        move_cmd_o.decel <= image_i.decel;
        move_cmd_o.current <= image_i.current;
        move_cmd_o.jerk <= image_i.jerk;
        move_cmd_o.dwell_ms <= dwell_word_i;
      end
    end
  end

  // [RULE_19] [RULE_20] one-cycle strobes
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      hold_o <= 1'b0;
      resume_o <= 1'b0;
      cancel_hold_o <= 1'b0;
    end else begin
      hold_o <= go_hold;
      resume_o <= go_resume;
      cancel_hold_o <= go_move;
    end
  end

  // [RULE_10] segment store levels
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prog_asm_o <= 1'b0;
      read_asm_o <= 1'b0;
      mode_config_o <= 1'b0;
    end else if (update_i) begin
      prog_asm_o <= cmd_mode && image_i.primary_command_word[`SMC_P_PRG_ASM];
      read_asm_o <= cmd_mode && image_i.primary_command_word[`SMC_P_RD_ASM];
      mode_config_o <= !cmd_mode;
    end
  end

  // [RULE_06] [RULE_12] presets
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      feedback_load_o <= 1'b0;
      feedback_value_o <= 32'sh0;
      motor_pos_load_o <= 1'b0;
      motor_pos_value_o <= 32'sh0;
    end else begin
      feedback_load_o <= go_enc;
      motor_pos_load_o <= go_preset;
      if (go_enc) begin
        feedback_value_o <= image_i.position;
      end
      if (go_preset) begin
        motor_pos_value_o <= mod[`SMC_M_FROM_FEEDBACK] ? scaled[31:0]
                                                       : image_i.position;
      end
    end
  end

  // -----------------------------------------------------------------------
  // immediate stop sequence
  // -----------------------------------------------------------------------
  logic [CW-1:0] short_cnt_reg;
  logic stop_done;
  // [RULE_18] short windings for a bounded time
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      short_cnt_reg <= '0;
      windings_short_o <= 1'b0;
    end else if (go_stop) begin
      short_cnt_reg <= CW'(SHORT_CYC - 1);
      windings_short_o <= 1'b1;
    end else if (short_cnt_reg != '0) begin
      short_cnt_reg <= short_cnt_reg - 1'b1;
    end else begin
      windings_short_o <= 1'b0;
    end
  end
  assign stop_done = windings_short_o && (short_cnt_reg == '0);

  // -----------------------------------------------------------------------
  // status flags
  // -----------------------------------------------------------------------
  // hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_error_o <= 1'b0;
      power_fault_o <= 1'b0;
      move_complete_o <= 1'b0;
      position_invalid_o <= 1'b0;
      stopped_o <= 1'b0;
    end else begin
      // [RULE_11] reset errors
      cmd_error_o <= cmd_error_i | (cmd_error_o & ~go_reset);
      power_fault_o <= power_fault_i | (power_fault_o & ~go_reset);
      // [RULE_11] [RULE_13] move complete clear
      move_complete_o <= move_done_i |
                         (move_complete_o & ~go_reset & ~go_preset);
      // [RULE_17] [RULE_13] invalid only if stopped mid-move
      position_invalid_o <= (go_stop & move_active_i) |
                            (position_invalid_o & ~go_preset);
      // [RULE_18] stopped once short released
      stopped_o <= stop_done | (stopped_o & ~go_move);
    end
  end

  // [RULE_22] [RULE_23] current enable refused on configuration error
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cfg_error_o <= 1'b0;
      current_enable_o <= 1'b0;
    end else begin
      cfg_error_o <= cfg_err;
      current_enable_o <= mod[`SMC_M_ENABLE] && !cfg_err && !go_stop &&
                          !(windings_short_o && !stop_done);
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  // last absolute bit seen, kept apart from the edge finder
  logic abs_seen_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      abs_seen_reg <= 1'b0;
    end else if (update_i) begin
      abs_seen_reg <= image_i.primary_command_word[`SMC_P_ABS];
    end
  end
  property p_edge_only;
    @(posedge clk_i) disable iff (reset_i)
      (update_i && image_i.primary_command_word[`SMC_P_ABS] && abs_seen_reg)
      |=> !(move_cmd_o.valid && move_cmd_o.kind == SMC_MV_ABS);
  endproperty
  a_edge_only: assert property (p_edge_only) // [RULE_01]
    else $error("absolute move started without a rising edge");
  property p_enc_load;
    @(posedge clk_i) disable iff (reset_i)
      go_enc |=> feedback_load_o && feedback_value_o == $past(image_i.position);
  endproperty
  a_enc_load: assert property (p_enc_load) // [RULE_06]
    else $error("feedback counter not loaded from position");
  property p_asm_type;
    @(posedge clk_i) disable iff (reset_i)
      go_asm |=> move_cmd_o.valid &&
        (move_cmd_o.kind == ($past(asm_dwell) ? SMC_MV_DWELL : SMC_MV_BLEND));
  endproperty
  a_asm_type: assert property (p_asm_type) // [RULE_07]
    else $error("assembled move type wrong");
  property p_reset_keeps_invalid;
    @(posedge clk_i) disable iff (reset_i)
      (go_reset && !go_preset && position_invalid_o) |=> position_invalid_o;
  endproperty
  a_reset_keeps_invalid: assert property (p_reset_keeps_invalid) // [RULE_11]
    else $error("error reset cleared position invalid");
  property p_preset_clear;
    @(posedge clk_i) disable iff (reset_i)
      (go_preset && !move_done_i) |=> !move_complete_o && !position_invalid_o;
  endproperty
  a_preset_clear: assert property (p_preset_clear) // [RULE_13]
    else $error("preset left status flags set");
  property p_idle_stop;
    @(posedge clk_i) disable iff (reset_i)
      (go_stop && !move_active_i && !position_invalid_o && !go_preset)
      |=> !position_invalid_o;
  endproperty
  a_idle_stop: assert property (p_idle_stop) // [RULE_17]
    else $error("idle stop invalidated position");
  property p_short_then_stopped;
    @(posedge clk_i) disable iff (reset_i)
      $fell(windings_short_o) |-> stopped_o;
  endproperty
  a_short_then_stopped: assert property (p_short_then_stopped) // [RULE_18]
    else $error("stopped flag not set at short release");
  property p_no_enable_on_cfg;
    @(posedge clk_i) disable iff (reset_i)
      cfg_err |=> !current_enable_o;
  endproperty
  a_no_enable_on_cfg: assert property (p_no_enable_on_cfg) // [RULE_23]
    else $error("current enabled under configuration error");
  property p_jog_dir;
    @(posedge clk_i) disable iff (reset_i)
      go_run_ccw_continuous |=> move_cmd_o.ccw && move_cmd_o.valid;
  endproperty
  a_jog_dir: assert property (p_jog_dir) // [RULE_14]
    else $error("counter-clockwise jog lost direction");

endmodule : smc_decoder
`default_nettype wire

//--- core/smc_defs.svh
// smc_defs.svh: bit positions, configuration check masks and codes, and timing counts for the
// motion command decoder. assumes a 200 MHz core clock.
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// -----------------------------------------------------------------------
// primary command word bit positions
// -----------------------------------------------------------------------
`define SMC_P_ABS 0
`define SMC_P_REL 1
`define SMC_P_HOLD 2
`define SMC_P_RESUME 3
`define SMC_P_ISTOP 4
`define SMC_P_HOME_CW 5
`define SMC_P_HOME_CCW 6
`define SMC_P_RUN_CW_CONTINUOUS 7
`define SMC_P_RUN_CCW_CONTINUOUS 8
`define SMC_P_PRESET_POS 9
`define SMC_P_RESET_ERR 10
`define SMC_P_RD_ASM 11
`define SMC_P_PRG_ASM 12
`define SMC_P_RUN_ASM 13
`define SMC_P_PRESET_ENC 14
`define SMC_P_MODE 15

// -----------------------------------------------------------------------
// modifier command word bit positions
// -----------------------------------------------------------------------
`define SMC_M_BLEND_REV 4
`define SMC_M_REG_MOVE 7
`define SMC_M_ASM_TYPE 9
`define SMC_M_FROM_FEEDBACK 13
`define SMC_M_ENABLE 15

// -----------------------------------------------------------------------
// configuration word checks
// -----------------------------------------------------------------------
`define SMC_CFG0_RSVD_MASK 16'h8000
`define SMC_CFG1_RSVD_MASK 16'h7FB8
`define SMC_CFG0_ENC_BIT 10
`define SMC_CFG0_STALL_BIT 13
`define SMC_IN_FN_BAD 3'h7
`define SMC_IN_FN_GP 3'h0

// -----------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------
`define SMC_CLK_MHZ 200
`define SMC_SHORT_MS 300
// longest time rounds down
`define SMC_SHORT_CYC (`SMC_SHORT_MS * 1000 * `SMC_CLK_MHZ)

`endif

//--- core/smc_pkg.sv
// smc_pkg: types shared by the motion command decoder files.
// assumes smc_defs.svh is on the include path.
`default_nettype none
package smc_pkg;

  typedef struct packed {
    logic [15:0] primary_command_word;
    logic [15:0] modifier_command_word;
    logic signed [31:0] position;
    logic [31:0] velocity;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] current;
    logic [15:0] jerk;
  } smc_image_t;

  typedef enum logic [3:0] {
    SMC_MV_NONE,
    SMC_MV_ABS,
    SMC_MV_REL,
    SMC_MV_JOG,
    SMC_MV_REG,
    SMC_MV_HOME,
    SMC_MV_BLEND,
    SMC_MV_DWELL
  } smc_move_t;

  typedef struct packed {
    logic valid;
    smc_move_t kind;
    logic ccw;
    logic signed [31:0] position;
    logic [31:0] velocity;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [15:0] current;
    logic [15:0] jerk;
    logic [15:0] dwell_ms;
  } smc_move_cmd_t;

endpackage : smc_pkg
`default_nettype wire

//--- core/smc_edge_detect.sv
// smc_edge_detect: rising edge finder for a word sampled on an update
// strobe. assumes the word is steady between strobes.
`default_nettype none
module smc_edge_detect #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // sampled word
  input wire logic update_i,
  input wire logic [W-1:0] word_i,
  // result
  output logic [W-1:0] rise_o
);

  logic [W-1:0] prev_reg;

  // zero after reset so a word already high counts as a new command
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      prev_reg <= '0;
    end else if (update_i) begin
      prev_reg <= word_i;
    end
  end

  assign rise_o = update_i ? (word_i & ~prev_reg) : '0;

endmodule : smc_edge_detect
`default_nettype wire

//--- core/smc_cfg_check.sv
// smc_cfg_check: static checks on configuration words.
// assumes the words are held steady by the configuration path.
`include "smc_defs.svh"
`default_nettype none
module smc_cfg_check (
  // configuration
  input wire logic [15:0] cfg0_i,
  input wire logic [15:0] cfg1_i,
  input wire logic param_bad_i,
  // result
  output logic cfg_error_o
);

  // input function codes sit in three-bit fields 0, 3 and 6
  wire logic [2:0] fn1 = cfg0_i[2:0];
  wire logic [2:0] fn2 = cfg0_i[5:3];
  wire logic [2:0] fn3 = cfg0_i[8:6];
  wire logic rsvd_set = |(cfg0_i & `SMC_CFG0_RSVD_MASK) |
                        |(cfg1_i & `SMC_CFG1_RSVD_MASK);
  wire logic dup12 = (fn1 == fn2) && (fn1 != `SMC_IN_FN_GP);
  wire logic dup13 = (fn1 == fn3) && (fn1 != `SMC_IN_FN_GP);
  wire logic dup23 = (fn2 == fn3) && (fn2 != `SMC_IN_FN_GP);
  wire logic stall_no_enc = cfg0_i[`SMC_CFG0_STALL_BIT] &&
                            !cfg0_i[`SMC_CFG0_ENC_BIT];
  wire logic bad_code = (fn1 == `SMC_IN_FN_BAD) ||
                        (fn2 == `SMC_IN_FN_BAD) ||
                        (fn3 == `SMC_IN_FN_BAD);

  // [RULE_22] any invalid setting
  assign cfg_error_o = rsvd_set | param_bad_i | dup12 | dup13 | dup23 |
                       stall_no_enc | bad_code;

endmodule : smc_cfg_check
`default_nettype wire

//--- testbench/smc_master_model.sv
// smc_master_model: network master writing the cyclic output image.
// assumes one update per call of send, two when z is set, launched 1 ns after a clock edge.
`default_nettype none
module smc_master_model
  import smc_pkg::*;
(
  // clock
  input wire logic clk_i,
  // cyclic output image
  output logic update_o,
  output var smc_image_t image_o,
  output logic [15:0] dwell_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    update_o = 1'b0;
    image_o = '0;
    dwell_o = 16'h0000;
  end

  task automatic send(input logic [15:0] p, input logic [15:0] m,
                      input logic signed [31:0] pos, input logic [15:0] dw,
                      input logic z);
    if (z) begin
      @(posedge clk_i);
      #1;
      image_o.primary_command_word = 16'h0000;
      update_o = 1'b1;
    end
    @(posedge clk_i);
    #1;
    image_o = '{p, m, pos, 32'h0000_1000, 16'h0010, 16'h0020, 16'h0005,
                16'h0000};
    dwell_o = dw;
    update_o = 1'b1;
    @(posedge clk_i);
    #1;
    update_o = 1'b0;
  endtask : send
endmodule : smc_master_model
`default_nettype wire

//--- testbench/smc_decoder_tb.sv
// smc_decoder_tb: self-checking bench for the motion command decoder.
// assumes the master model drives the image; engine status comes from here.
`default_nettype none
module smc_decoder_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import smc_pkg::*;
  // short window kept tiny so the stop scenario runs fast
  localparam int SC = 20;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic upd, bad = 1'b0, act = 1'b0, done = 1'b0, cerr = 1'b0, pf = 1'b0;
  smc_image_t img;
  logic [15:0] dw, cfg0 = 16'h0000, cfg1 = 16'h0000;
  logic signed [31:0] fbp = 1000, fbv, mpv;
  smc_move_cmd_t mc, mv;
  logic [5:0] got = '0;
  logic hold, res, canc, prg, rda, mcfg, fl, mp, sh, cen;
  logic cerr_o, pf_o, mcmp, pinv, stp, cfe;
  int error_cnt = 0;
  int n_tests = 0;

  always #2.5 clk_i = ~clk_i;

  smc_master_model smc_master_model_inst (.clk_i(clk_i), .update_o(upd),
    .image_o(img), .dwell_o(dw));

  smc_decoder #(.SHORT_CYC(SC), .CW(24)) smc_decoder_inst (.clk_i(clk_i),
    .reset_i(reset_i), .update_i(upd), .image_i(img), .dwell_word_i(dw),
    .cfg0_i(cfg0), .cfg1_i(cfg1), .param_bad_i(bad), .move_active_i(act),
    .move_done_i(done), .cmd_error_i(cerr), .power_fault_i(pf),
    .feedback_pos_i(fbp), .steps_per_turn_i(32'd200),
    .pulses_per_turn_i(32'd400), .move_cmd_o(mc), .hold_o(hold),
    .resume_o(res), .cancel_hold_o(canc), .prog_asm_o(prg),
    .read_asm_o(rda), .mode_config_o(mcfg), .feedback_load_o(fl),
    .feedback_value_o(fbv), .motor_pos_load_o(mp),
    .motor_pos_value_o(mpv), .windings_short_o(sh),
    .current_enable_o(cen), .cmd_error_o(cerr_o), .power_fault_o(pf_o),
    .move_complete_o(mcmp), .position_invalid_o(pinv), .stopped_o(stp),
    .cfg_error_o(cfe));

  // pulses are caught here so no check depends on the exact cycle
  always @(posedge clk_i) begin
    got <= got | {mc.valid, hold, res, canc, fl, mp};
    if (mc.valid === 1'b1) mv <= mc;
  end

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk

  task automatic final_report();
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report

  task automatic cmd(input logic [15:0] p, input logic [15:0] m,
                     input logic z);
    got = '0;
    smc_master_model_inst.send(p, m, -32'sd1234, 16'h0BB8, z);
    repeat (3) @(posedge clk_i);
    #1;
  endtask : cmd

  task automatic engine_events();
    @(posedge clk_i);
    #1;
    {done, cerr, pf} = 3'b111;
    @(posedge clk_i);
    #1;
    {done, cerr, pf} = 3'b000;
  endtask : engine_events

  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_moves();
    logic [15:0] tp[10] = '{16'h0001, 16'h0002, 16'h0080, 16'h0100,
      16'h0080, 16'h0020, 16'h0040, 16'h2000, 16'h2000, 16'h2000};
    logic [15:0] tm[10] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0080, 16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0200};
    smc_move_t tk[10] = '{SMC_MV_ABS, SMC_MV_REL, SMC_MV_JOG, SMC_MV_JOG,
      SMC_MV_REG, SMC_MV_HOME, SMC_MV_HOME, SMC_MV_BLEND, SMC_MV_BLEND,
      SMC_MV_DWELL};
    logic tc[10] = '{0, 0, 0, 1, 0, 0, 1, 0, 1, 0};
    for (int i = 0; i < 10; i++) begin
      cmd(tp[i], tm[i], 1'b1);
      chk("move_valid", got[5], 1'b1); // move taken
      chk("move_kind", mv.kind, tk[i]); // kind
      chk("cancel_hold", got[2], 1'b1); // hold dropped
      chk("move_pos", mv.position, -32'sd1234); // parameters
      chk("move_vel", mv.velocity, 32'h0000_1000); // velocity
      chk("move_acc", {mv.accel, mv.decel}, 32'h0010_0020); // ramps
      chk("move_cur", {mv.current, mv.jerk}, 32'h0005_0000); // tail
      if (i < 9) chk("move_ccw", mv.ccw, tc[i]); // way
    end
    chk("dwell_ms", mv.dwell_ms, 16'h0BB8); // dwell word
  endtask : t_moves

  task automatic t_edges();
    cmd(16'h0001, 16'h0000, 1'b1);
    cmd(16'h0001, 16'h0000, 1'b0);
    chk("held_bit", got[5], 1'b0); // no new edge
    cmd(16'h8001, 16'h0000, 1'b1);
    chk("cfg_mode_move", got[5], 1'b0); // config mode idle
    chk("cfg_mode", mcfg, 1'b1); // mode shown
    cmd(16'h1000, 16'h0000, 1'b1);
    chk("prog_asm", {prg, rda}, 2'b10); // program level
    cmd(16'h0800, 16'h0000, 1'b1);
    chk("read_asm", {prg, rda, mcfg}, 3'b010); // read level
    cmd(16'h0004, 16'h0000, 1'b1);
    chk("hold", got[4], 1'b1); // hold strobe
    cmd(16'h0008, 16'h0000, 1'b1);
    chk("resume", got[3], 1'b1); // resume strobe
  endtask : t_edges

  task automatic t_stop(input logic moving);
    int k;
    act = moving;
    cmd(16'h0010, 16'h8000, 1'b1);
    act = 1'b0;
    chk("short_on", {sh, cen}, 2'b10); // windings shorted
    chk("pos_invalid", pinv, moving); // only if moving
    k = 0;
    while (sh !== 1'b0 && k < SC) begin
      @(posedge clk_i);
      #1;
      k++;
    end
    chk("short_len", k < SC, 1'b1); // short bounded
    if (k >= SC) final_report();
    chk("stopped", stp, 1'b1); // stopped flag
    repeat (2) @(posedge clk_i);
    #1;
    chk("current_back", cen, 1'b1); // current restored
  endtask : t_stop

  task automatic t_reset_err();
    engine_events();
    chk("flags_set", {cerr_o, pf_o, mcmp, pinv}, 4'hF); // set
    cmd(16'h0400, 16'h8000, 1'b1);
    chk("flags_clr", {cerr_o, pf_o, mcmp, pinv}, 4'h1); // clear
  endtask : t_reset_err

  task automatic t_presets();
    cmd(16'h4000, 16'h8000, 1'b1);
    chk("fb_load", got[1], 1'b1); // encoder load
    chk("fb_value", fbv, -32'sd1234); // encoder value
    engine_events();
    cmd(16'h0200, 16'h8000, 1'b1);
    chk("mp_load", got[0], 1'b1); // preset strobe
    chk("mp_value", mpv, -32'sd1234); // from position
    chk("mp_flags", {mcmp, pinv}, 2'b00); // flags cleared
    cmd(16'h0200, 16'hA000, 1'b1);
    chk("mp_scaled", mpv, 32'sd500); // scaled feedback
  endtask : t_presets

  task automatic t_cfg();
    logic [32:0] tab[8] = '{{16'h8000, 16'h0000, 1'b0},
      {16'h0000, 16'h0008, 1'b0}, {16'h0000, 16'h0000, 1'b1},
      {16'h0009, 16'h0000, 1'b0}, {16'h2000, 16'h0000, 1'b0},
      {16'h0007, 16'h0000, 1'b0}, {16'h2400, 16'h0000, 1'b0},
      {16'h0000, 16'h0000, 1'b0}};
    for (int i = 0; i < 8; i++) begin
      {cfg0, cfg1, bad} = tab[i];
      repeat (2) @(posedge clk_i);
      #1;
      chk("cfg_err", cfe, i < 6); // configuration checks
      if (i == 0) begin
        cmd(16'h0000, 16'h8000, 1'b1);
        chk("cur_refused", cen, 1'b0); // refused on error
      end
    end
    cmd(16'h0000, 16'h8000, 1'b1);
    chk("cur_on", cen, 1'b1); // enabled when clean
  endtask : t_cfg

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    #1;
    reset_i = 1'b0;
    chk("rst_flags", {stp, pinv, mcmp, cfe, sh}, 5'h00); // idle
    t_moves();
    t_edges();
    t_stop(1'b1);
    t_reset_err();
    t_presets();
    t_stop(1'b0);
    t_cfg();
    final_report();
  end
endmodule : smc_decoder_tb
`default_nettype wire
